// ==== verilog/sac_ctrl.sv ====
// control of a 10-bit successive-approximation converter with register file
// assumes an analog comparator and tap selector outside; comparator and
// stop-mode levels arrive asynchronously and are synchronised here
// Function
// - in stop mode the converter halts all conversion activity
// - result read coinciding with result store: read old value, then store
// - config write at end of conversion wins; no store, no interrupt
// - channel-select write leaves the conversion-end flag unchanged
// - old-channel conversion ending before a channel write still stores
// - first result suspect if start within 1 us of enable or disabled
// - config writes may leave result registers undefined
// - results are 10-bit codes, one step per 1/1024 of full scale
// - conversion time includes the sampling interval
// - each completion outside stop mode without a config write stores, interrupts, and starts the next conversion
// - channel-select write aborts and restarts the running conversion
// - clearing start stops at once and keeps the stored result
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
module sac_ctrl
	import sac_pkg::*;
#(
	parameter int SAMPLE_CYCLES = sac_pkg::SAMPLE_BASE,
	parameter int BIT_CYCLES    = sac_pkg::BIT_CYC
) (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         resetn,
	// axi4-lite write address and data
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [sac_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	input  wire logic [sac_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	// axi4-lite write response
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	output logic [1:0]                        s_axi_bresp,
	// axi4-lite read
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	input  wire logic [sac_pkg::ADDR_W-1:0]   s_axi_araddr,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	output logic [sac_pkg::DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	// analog front end
	input  wire logic                         comp_in,
	output logic                              comparator_on,
	output logic                              sample_on,
	output logic [sac_pkg::RES_BITS-1:0]      tap_code,
	output logic [sac_pkg::CHAN_W-1:0]        analog_inputs_sel,
	output logic [sac_pkg::PCFG_W-1:0]        analog_port_cfg,
	// system
	input  wire logic                         stop_mode,
	output logic                              conv_end_irq
);
	import sac_pkg::*;

	if (BIT_CYCLES < 3 || BIT_CYCLES > 16 || SAMPLE_CYCLES < 1
		|| SAMPLE_CYCLES > 192) begin : g_bad
		$error("sac_ctrl: unsupported timing parameters");
	end

	localparam logic [7:0] BITC = 8'(BIT_CYCLES - 1);
	localparam logic [7:0] WARM = 8'(WARM_CYC);

	// synchronisers
	logic cmp_m_r, cmp_s_r, stop_m_r, stop_s_r;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			{cmp_m_r, cmp_s_r, stop_m_r, stop_s_r} <= 4'h0;
		end else begin
			cmp_m_r  <= comp_in;
			cmp_s_r  <= cmp_m_r;
			stop_m_r <= stop_mode;
			stop_s_r <= stop_m_r;
		end
	end

	// bus write path: address and data taken in either order
	logic              aw_got_r, w_got_r, bvalid_r;
	logic [7:0]        waddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic [1:0]        bresp_r;
	logic              aw_hs, w_hs, wr_do, wr_map;
	logic [7:0]        wa;
	logic [31:0]       wd;
	logic [3:0]        ws;

	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready  = !w_got_r && !bvalid_r;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs  = s_axi_wvalid && s_axi_wready;
	assign wa    = aw_got_r ? waddr_r : s_axi_awaddr;
	assign wd    = w_got_r ? wdata_r : s_axi_wdata;
	assign ws    = w_got_r ? wstrb_r : s_axi_wstrb;
	assign wr_do = (aw_got_r || aw_hs) && (w_got_r || w_hs) && !bvalid_r;
	assign wr_map = wa inside {OFS_MODE, OFS_CHAN, OFS_PCFG, OFS_RES10,
		OFS_RES8, OFS_IFLAG, OFS_STAT};
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			bvalid_r <= 1'b0;
			waddr_r  <= 8'h00;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_do) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			bvalid_r <= 1'b1;
			bresp_r  <= wr_map ? RESP_OKAY : RESP_SLVERR;
		end else begin
			if (aw_hs) begin
				aw_got_r <= 1'b1;
				waddr_r  <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// only the low byte lane carries register bits
	logic wr_mode, wr_chan, wr_pcfg, wr_flag, wr_cfg;
	assign wr_mode = wr_do && ws[0] && wa == OFS_MODE;
	assign wr_chan = wr_do && ws[0] && wa == OFS_CHAN;
	assign wr_pcfg = wr_do && ws[0] && wa == OFS_PCFG;
	assign wr_flag = wr_do && ws[0] && wa == OFS_IFLAG;
	assign wr_cfg  = wr_mode || wr_chan || wr_pcfg;

	// control registers
	logic [7:0]          mode_r;
	logic [CHAN_W-1:0]   chan_r;
	logic [PCFG_W-1:0]   pcfg_r;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode_r <= MODE_RST;
			chan_r <= CHAN_RST;
			pcfg_r <= PCFG_RST;
		end else begin
			if (wr_mode) mode_r <= wd[7:0];
			if (wr_chan) chan_r <= wd[CHAN_W-1:0];
			if (wr_pcfg) pcfg_r <= wd[PCFG_W-1:0];
		end
	end

	// converter sequencer
	sac_state_t          state_r;
	logic [7:0]          cnt_r, samp_len;
	logic [3:0]          bit_r;
	logic [RES_BITS-1:0] sar_r, sar_dec;
	logic                run, conv_done, store;

	assign run  = mode_r[MODE_START] && !stop_s_r;
	// sampling is counted inside the conversion time
	assign samp_len = 8'(SAMPLE_CYCLES - 1) + {2'h0, mode_r[MODE_THI:MODE_TLO]};
	assign sar_dec = cmp_s_r ? sar_r : (sar_r & ~(10'h001 << bit_r));
	assign conv_done = state_r == SAC_CONV && cnt_r == 8'h00 && bit_r == 4'h0;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r <= SAC_IDLE;
			cnt_r   <= 8'h00;
			bit_r   <= 4'h0;
			sar_r   <= RES_RST;
		end else if (!run || (wr_mode && !wd[MODE_START])) begin
			state_r <= SAC_IDLE;
		end else if (wr_chan || state_r == SAC_IDLE) begin
			state_r <= SAC_SAMPLE;
			cnt_r   <= samp_len;
			sar_r   <= RES_RST;
		end else begin
			unique case (state_r)
				SAC_SAMPLE: begin
					if (cnt_r == 8'h00) begin
						state_r <= SAC_CONV;
						cnt_r   <= BITC;
						bit_r   <= 4'(RES_BITS - 1);
						sar_r   <= 10'h200;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				SAC_CONV: begin
					if (cnt_r != 8'h00) begin
						cnt_r <= cnt_r - 8'h01;
					end else if (bit_r == 4'h0) begin
						state_r <= SAC_SAMPLE;
						cnt_r   <= samp_len;
						sar_r   <= sar_dec;
					end else begin
						// 10 trials halve the range each step
						bit_r <= bit_r - 4'h1;
						cnt_r <= BITC;
						sar_r <= sar_dec | (10'h001 << (bit_r - 4'h1));
					end
				end
				SAC_IDLE: state_r <= SAC_SAMPLE;
			endcase
		end
	end

	// a config write in the completion cycle wins and the store is lost
	assign store = conv_done && run && !wr_cfg;

	// result and flag; a read in the same cycle samples the old value first
	logic [RES_BITS-1:0] res_r;
	logic                flag_r, irq_r;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			res_r <= RES_RST;
			irq_r <= 1'b0;
		end else begin
			// config writes leave the old result in place
			if (store) res_r <= sar_dec;
			irq_r <= store;
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			flag_r <= 1'b0;
		end else if (store) begin
			flag_r <= 1'b1;
		end else if (wr_flag && !wd[IFLAG_BIT]) begin
			flag_r <= 1'b0;
		end
	end

	// first-result quality tracking
	logic [7:0] warm_r;
	logic       start_rise, first_bad_r, suspect_r;
	assign start_rise = wr_mode && wd[MODE_START] && !mode_r[MODE_START];
	always_ff @(posedge clk) begin
		if (!resetn) begin
			warm_r      <= 8'h00;
			first_bad_r <= 1'b0;
			suspect_r   <= 1'b0;
		end else begin
			if (!mode_r[MODE_CMPEN]) warm_r <= 8'h00;
			else if (warm_r != WARM) warm_r <= warm_r + 8'h01;
			if (start_rise) begin
				first_bad_r <= !mode_r[MODE_CMPEN] || warm_r != WARM;
			end else if (store) begin
				first_bad_r <= 1'b0;
			end
			if (store) suspect_r <= first_bad_r;
		end
	end

	// bus read path
	logic        rvalid_r, ar_hs;
	logic [31:0] rdata_r, rd_mux;
	logic [1:0]  rresp_r, rd_resp;
	assign s_axi_arready = !rvalid_r;
	assign ar_hs = s_axi_arvalid && !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;

	always_comb begin
		rd_mux  = 32'h0000_0000;
		rd_resp = RESP_OKAY;
		unique case (s_axi_araddr)
			OFS_MODE:  rd_mux = {24'h0, mode_r};
			OFS_CHAN:  rd_mux = {29'h0, chan_r};
			OFS_PCFG:  rd_mux = {28'h0, pcfg_r};
			OFS_RES10: rd_mux = {16'h0, res_r, 6'h00};
			OFS_RES8:  rd_mux = {24'h0, res_r[RES_BITS-1:2]};
			OFS_IFLAG: rd_mux = {31'h0, flag_r};
			OFS_STAT:  rd_mux = {28'h0, first_bad_r, suspect_r, stop_s_r,
				state_r != SAC_IDLE};
			default:   rd_resp = RESP_SLVERR;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= rd_resp;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// front-end outputs
	assign comparator_on     = mode_r[MODE_CMPEN] && !stop_s_r;
	assign sample_on         = state_r == SAC_SAMPLE;
	assign tap_code          = sar_r;
	assign analog_inputs_sel = chan_r;
	assign analog_port_cfg   = pcfg_r;
	assign conv_end_irq      = irq_r;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence done_s;
		conv_done && run && !wr_cfg;
	endsequence
	sequence stored_s;
		conv_end_irq && flag_r && state_r == SAC_SAMPLE;
	endsequence

	stop_idle_a: assert property (stop_s_r |=> state_r == SAC_IDLE)
		else $error("converter still active in stop mode");
	read_first_a: assert property (ar_hs && s_axi_araddr == OFS_RES10
		&& store |=> s_axi_rdata[15:6] == $past(res_r))
		else $error("result read did not return the old value");
	cfg_drop_a: assert property (conv_done && wr_cfg
		|=> !conv_end_irq && res_r == $past(res_r) ##1 !conv_end_irq)
		else $error("store or interrupt despite config write");
	chan_flag_a: assert property (wr_chan && flag_r |=> flag_r)
		else $error("channel write cleared the end flag");
	store_next_a: assert property (done_s |=> stored_s)
		else $error("completion did not store and restart");
	first_bad_a: assert property (start_rise && !mode_r[MODE_CMPEN]
		|=> first_bad_r)
		else $error("suspect first result not marked");
	chan_restart_a: assert property (wr_chan && run
		|=> state_r == SAC_SAMPLE && cnt_r == $past(samp_len))
		else $error("channel write did not restart sampling");
	stop_keep_a: assert property (wr_mode && !wd[MODE_START]
		&& mode_r[MODE_START] |=> state_r == SAC_IDLE
		&& res_r == $past(res_r))
		else $error("clearing start did not stop or altered result");
	conv_len_a: assert property ($rose(state_r == SAC_CONV)
		|-> $past(state_r) == SAC_SAMPLE)
		else $error("conversion began without sampling");
endmodule

// ==== verilog/sac_pkg.sv ====
// constants for the successive-approximation converter control block
// assumes a 40 MHz peripheral clock and an AXI4-Lite register bus
package sac_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register byte offsets
	localparam logic [7:0] OFS_MODE  = 8'h00;
	localparam logic [7:0] OFS_CHAN  = 8'h04;
	localparam logic [7:0] OFS_PCFG  = 8'h08;
	localparam logic [7:0] OFS_RES10 = 8'h0c;
	localparam logic [7:0] OFS_RES8  = 8'h10;
	localparam logic [7:0] OFS_IFLAG = 8'h14;
	localparam logic [7:0] OFS_STAT  = 8'h18;
	// field positions
	localparam int MODE_START = 7;
	localparam int MODE_CMPEN = 0;
	localparam int MODE_TLO   = 1;
	localparam int MODE_THI   = 6;
	localparam int IFLAG_BIT  = 0;
	localparam int RES_BITS   = 10;
	localparam int RES_SHIFT  = 6;
	localparam int CHAN_W     = 3;
	localparam int PCFG_W     = 4;
	// reset values
	localparam logic [7:0]          MODE_RST = 8'h00;
	localparam logic [CHAN_W-1:0]   CHAN_RST = 3'h0;
	localparam logic [PCFG_W-1:0]   PCFG_RST = 4'h0;
	localparam logic [RES_BITS-1:0] RES_RST  = 10'h000;
	// timing
	localparam int CLK_KHZ     = 40000;
	localparam int WARM_NS     = 1000;
	localparam int WARM_CYC    = (WARM_NS * CLK_KHZ + 999999) / 1000000;
	localparam int SAMPLE_BASE = 8;
	localparam int BIT_CYC     = 4;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_CONV} sac_state_t;
endpackage

// ==== dv/test_sac_ctrl.sv ====
// self-checking bench for the converter control block
// assumes sac_pkg and sac_ctrl compiled first; the bench drives every port
module test_sac_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	import sac_pkg::*;
	localparam int SC = 1;
	localparam int BC = 8;
	logic        clk, resetn, stop_mode, comp_in, conv_end_irq;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        cmp_on, smp_on;
	logic [9:0]  tap, target, t_old;
	logic [2:0]  sel;
	logic [3:0]  pcfg, wstrb, strb_v;
	logic [33:0] exp_q[$];
	logic [31:0] mask_q[$];
	int          fail_count, checks, irq_count, seed, p, c;

	sac_ctrl #(.SAMPLE_CYCLES(SC), .BIT_CYCLES(BC)) dut_u (
		.clk(clk), .resetn(resetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.comp_in(comp_in), .comparator_on(cmp_on), .sample_on(smp_on),
		.tap_code(tap), .analog_inputs_sel(sel), .analog_port_cfg(pcfg),
		.stop_mode(stop_mode), .conv_end_irq(conv_end_irq));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ideal analog input: comparator says input >= tap
	always @(posedge clk) comp_in <= (target >= tap);
	always @(posedge clk) if (conv_end_irq === 1'b1) irq_count <= irq_count + 1;

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// read results are judged here, in the order they were asked for
	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			if (exp_q.size() == 0)
				fail_count++;
			else
				check({rresp, rdata & mask_q.pop_front()}, exp_q.pop_front());
		end
	end

	function automatic logic [33:0] res10(input logic [9:0] t);
		return {2'h0, 16'h0, t, 6'h0};
	endfunction

	// called just after a rising edge; ends just after one
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] r);
		logic ap, wp, ta, tw;
		ap = 1'b1;
		wp = 1'b1;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= strb_v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (ap || wp) begin
			@(negedge clk);
			ta = ap && awready;
			tw = wp && wready;
			@(posedge clk);
			if (ta) begin
				awvalid <= 1'b0;
				ap = 1'b0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				wp = 1'b0;
			end
		end
		do @(negedge clk); while (bvalid !== 1'b1);
		check({32'h0, bresp}, {32'h0, r});
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e,
		input logic [31:0] m);
		exp_q.push_back(e);
		mask_q.push_back(m);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		@(posedge clk);
	endtask

	// returns one edge after the edge that raised the pulse
	task automatic wait_irq();
		int i;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (conv_end_irq !== 1'b1 && i < 2000);
		check({33'h0, conv_end_irq}, 34'h1);
		@(posedge clk);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#(25 * 40000);
		fail_count++;
		report_and_stop();
	end

	initial begin
		seed = 25590;
		{resetn, stop_mode, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, target} = '0;
		{wstrb, strb_v} = 8'hff;
		irq_count = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 8'h1c; a += 4)
			rd(8'(a), 34'h0, 32'hffffffff);
		rd(8'h1c, {RESP_SLVERR, 32'h0}, 32'hffffffff);
		wr(8'h1c, 8'h00, RESP_SLVERR);
		wr(OFS_PCFG, 8'h05, RESP_OKAY);
		rd(OFS_PCFG, 34'h5, 32'hffffffff);
		check({30'h0, pcfg}, 34'h5);
		// low lane disabled: the write is answered but must not land
		strb_v = 4'he;
		wr(OFS_PCFG, 8'h0a, RESP_OKAY);
		strb_v = 4'hf;
		rd(OFS_PCFG, 34'h5, 32'hffffffff);
		// warm-up respected so the first result is trusted
		wr(OFS_MODE, 8'h01, RESP_OKAY);
		repeat (45) @(posedge clk);
		target = 10'($random(seed));
		wr(OFS_MODE, 8'h81, RESP_OKAY);
		wait_irq();
		rd(OFS_RES10, res10(target), 32'hffffffff);
		rd(OFS_RES8, {26'h0, target[9:2]}, 32'hffffffff);
		rd(OFS_IFLAG, 34'h1, 32'h1);
		rd(OFS_STAT, 34'h0, 32'h4);
		wait_irq();
		p = 0;
		do begin
			@(negedge clk);
			p++;
		end while (conv_end_irq !== 1'b1);
		@(posedge clk);
		// read landing on the store edge sees the old code
		t_old = target;
		target = 10'($random(seed));
		repeat (p - 2) @(posedge clk);
		rd(OFS_RES10, res10(t_old), 32'hffffffff);
		rd(OFS_RES10, res10(target), 32'hffffffff);
		// channel write on the store edge wins, store dropped for good
		wait_irq();
		t_old = target;
		target = 10'($random(seed));
		repeat (p - 2) @(posedge clk);
		c = irq_count;
		wr(OFS_CHAN, 8'h03, RESP_OKAY);
		repeat (2) @(posedge clk);
		check(34'(irq_count), 34'(c));
		rd(OFS_RES10, res10(t_old), 32'hffffffff);
		rd(OFS_IFLAG, 34'h1, 32'h1);
		check({31'h0, sel}, 34'h3);
		wait_irq();
		rd(OFS_RES10, res10(target), 32'hffffffff);
		wait_irq();
		wr(OFS_IFLAG, 8'h00, RESP_OKAY);
		rd(OFS_IFLAG, 34'h0, 32'h1);
		// clearing start halts and keeps the last code
		wr(OFS_MODE, 8'h01, RESP_OKAY);
		c = irq_count;
		repeat (2 * p) @(posedge clk);
		check(34'(irq_count), 34'(c));
		rd(OFS_RES10, res10(target), 32'hffffffff);
		// start with comparator off marks the next result suspect
		wr(OFS_MODE, 8'h00, RESP_OKAY);
		wr(OFS_MODE, 8'h80, RESP_OKAY);
		rd(OFS_STAT, 34'h8, 32'h8);
		// the suspect mark moves to the stored result, then is discarded
		wait_irq();
		rd(OFS_STAT, 34'h4, 32'hc);
		wr(OFS_MODE, 8'h01, RESP_OKAY);
		repeat (45) @(posedge clk);
		wr(OFS_MODE, 8'h81, RESP_OKAY);
		wait_irq();
		stop_mode <= 1'b1;
		repeat (4) @(posedge clk);
		check({33'h0, cmp_on}, 34'h0);
		c = irq_count;
		repeat (2 * p) @(posedge clk);
		check(34'(irq_count), 34'(c));
		check({33'h0, smp_on}, 34'h0);
		stop_mode <= 1'b0;
		wr(OFS_IFLAG, 8'h00, RESP_OKAY);
		rd(OFS_IFLAG, 34'h0, 32'h1);
		wait_irq();
		rd(OFS_RES10, res10(target), 32'hffffffff);
		wr(OFS_MODE, 8'h00, RESP_OKAY);
		report_and_stop();
	end
endmodule
